/* rtl/rate_alarm.sv */
`timescale 1ns/10ps
module rate_alarm (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic                ce,
  input  wire logic                sample,
  input  wire logic [9:0]          period,
  input  wire logic signed [15:0]  process_value,
  input  wire logic signed [15:0]  alarm_value,
  output logic                     rate_alarm
);
  import sp_alarm_pkg::*;

  typedef struct packed {
    logic [9:0]         count;
    logic signed [15:0] previous;
    logic               alarm;
  } rate_state_t;

  rate_state_t        state;
  rate_state_t        next_state;
  logic signed [16:0] diff;

  // ----------------------------------------------------------------------------
  // Period counter and difference
  // ----------------------------------------------------------------------------
  // Period zero is out of range and behaves as one sample.
  always_comb begin
    next_state = state;
    diff       = 17'(process_value) - 17'(state.previous);
    if (sample) begin
      if (state.count + 10'h001 >= period) begin // see [RULE17]
        next_state.count    = '0;
        next_state.previous = process_value;
        next_state.alarm    = diff > 17'(alarm_value); // see [RULE16]
      end else begin
        next_state.count = state.count + 10'h001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign rate_alarm = state.alarm;

  property p_count_bound;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && sample && period != 10'h000) |=> state.count < $past(period);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("rate count overran"); // see [RULE17]

endmodule : rate_alarm

/* rtl/remote_scaler.sv */
`timescale 1ns/10ps
module remote_scaler (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic                ce,
  input  wire logic                sample,
  input  wire logic [2:0]          remote_input_type,
  input  wire logic [15:0]         remote_raw,
  input  wire logic signed [15:0]  remote_upper_limit,
  input  wire logic signed [15:0]  remote_lower_limit,
  output logic signed [15:0]       remote_setpoint,
  output logic                     remote_error
);
  import sp_alarm_pkg::*;

  typedef struct packed {
    logic signed [15:0] value;
    logic               err;
  } scaler_state_t;

  scaler_state_t      state;
  scaler_state_t      next_state;
  logic signed [17:0] span;
  logic signed [17:0] offset;
  logic signed [17:0] live;
  logic signed [35:0] prod;
  logic signed [35:0] scaled;
  logic signed [17:0] margin;
  logic signed [35:0] lo_bound;
  logic signed [35:0] hi_bound;

  // ----------------------------------------------------------------------------
  // Scaling per input type
  // ----------------------------------------------------------------------------
  // The live zero offsets the 4-20 mA and 1-5 V ranges by one fifth of scale.
  always_comb begin
    next_state = state;
    offset     = 18'sd0;
    if (remote_input_type == IN_4_20MA || remote_input_type == IN_1_5V) begin
      offset = 18'(INPUT_FULL_SCALE / 5);
    end
    live   = 18'($signed({2'b00, remote_raw})) - offset;
    span   = 18'(remote_upper_limit) - 18'(remote_lower_limit);
    prod   = 36'(live) * 36'(span);
    scaled = 36'(remote_lower_limit)
             + prod / $signed(36'(18'(INPUT_FULL_SCALE) - offset)); // see [RULE7] see [RULE10]
    margin   = 18'(span / $signed(18'(MARGIN_DIV)));
    lo_bound = 36'(remote_lower_limit) - 36'(margin);
    hi_bound = 36'(remote_upper_limit) + 36'(margin);
    if (sample) begin
      // Outside the remote limits the value is pinned to the nearer limit.
      next_state.err = (scaled < lo_bound) || (scaled > hi_bound); // see [RULE11]
      if (scaled < 36'(remote_lower_limit)) begin
        next_state.value = remote_lower_limit;
      end else if (scaled > 36'(remote_upper_limit)) begin
        next_state.value = remote_upper_limit;
      end else begin
        next_state.value = 16'(scaled);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign remote_setpoint = state.value;
  assign remote_error    = state.err;

  property p_clamp_err;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && sample && scaled > hi_bound) |=> remote_error && remote_setpoint == $past(remote_upper_limit);
  endproperty
  a_clamp_err: assert property (p_clamp_err) else $error("remote clamp missing"); // see [RULE11]

endmodule : remote_scaler

/* rtl/setpoint_select_alarm_combine.sv */
`timescale 1ns/10ps
module setpoint_select_alarm_combine #(
  parameter int unsigned SAMPLE_DIV = sp_alarm_pkg::SAMPLE_CYCLES
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic                ce,
  // Configuration writes: legal values are loaded while cfg_write is high, remote enable, tracking and limits only with self-tuning off.
  input  wire logic                cfg_write,
  input  wire logic [7:0]          integrated_alarm_mask_in,
  input  wire logic [2:0]          remote_input_type_in,
  input  wire logic signed [15:0]  remote_upper_limit_in,
  input  wire logic signed [15:0]  remote_lower_limit_in,
  input  wire logic                remote_enable_in,
  input  wire logic                tracking_in,
  input  wire logic                manual_limit_enable_in,
  input  wire logic                alarm_sp_target_in,
  input  wire logic                soak_unit_hours_in,
  input  wire logic [9:0]          rate_period_in,
  input  wire logic [1:0]          cool_tune_in,
  // Operating conditions.
  input  wire logic                self_tuning,
  input  wire logic                program_enabled,
  input  wire logic                heat_cool_two_pid,
  input  wire logic                ramp_distinct,
  input  wire logic [4:0]          alarm1_type,
  input  wire logic                remote_mode,
  input  wire logic                manual_mode,
  input  wire logic                flash_phase,
  // Status flags and data.
  input  wire logic [3:0]          alarm_flags,
  input  wire logic                heater_burnout_alarm,
  input  wire logic                heater_short_alarm,
  input  wire logic                input_error,
  input  wire logic [15:0]         remote_raw,
  input  wire logic signed [15:0]  process_value,
  input  wire logic signed [15:0]  rate_alarm_value,
  input  wire logic signed [15:0]  ramping_setpoint,
  input  wire logic signed [15:0]  target_setpoint,
  input  wire logic signed [15:0]  local_setpoint_in,
  input  wire logic                local_setpoint_write,
  input  wire logic signed [15:0]  sp_upper_limit,
  input  wire logic signed [15:0]  sp_lower_limit,
  input  wire logic signed [15:0]  manual_mv,
  input  wire logic signed [15:0]  mv_upper_limit,
  input  wire logic signed [15:0]  mv_lower_limit,
  // Results.
  output logic                     integrated_alarm,
  output logic signed [15:0]       control_setpoint,
  output logic signed [15:0]       local_setpoint,
  output logic signed [15:0]       alarm_setpoint,
  output logic signed [15:0]       manual_output,
  output logic                     remote_error,
  output logic                     remote_indicator,
  output logic                     remote_monitor_blank,
  output logic                     rate_change_alarm,
  output logic                     soak_unit_hours,
  output logic [3:0]               cool_tune_method
);
  import sp_alarm_pkg::*;

  typedef struct packed {
    logic [7:0]         mask;
    logic [2:0]         in_type;
    logic [15:0]        rem_upper;
    logic [15:0]        rem_lower;
    logic               rem_enable;
    logic               tracking;
    logic               man_limit;
    logic               sp_target;
    logic               soak_hours;
    logic [9:0]         rate_period;
    logic [1:0]         cool_tune;
    logic [22:0]        div;
    logic               sample;
    logic               remote_prev;
    logic               alarm;
    logic signed [15:0] ctrl_sp;
    logic signed [15:0] local_sp;
    logic signed [15:0] alarm_sp;
    logic signed [15:0] man_out;
    logic               err;
    logic               ind;
    logic               mon_blank;
    logic               soak_out;
    logic [3:0]         cool_out;
  } top_state_t;

  top_state_t         state;
  top_state_t         next_state;
  logic signed [15:0] remote_sp;
  logic               remote_err_raw;
  logic               rate_raw;
  logic [7:0]         flags;
  logic               rem_active;
  logic               sel_allowed;
  logic signed [15:0] rem_limited;

  // ----------------------------------------------------------------------------
  // Remote input scaling and rate-of-change alarm
  // ----------------------------------------------------------------------------
  remote_scaler u_scaler (
    .clk_sys            (clk_sys),
    .rst_b              (rst_b),
    .ce                 (ce),
    .sample             (state.sample),
    .remote_input_type  (state.in_type),
    .remote_raw         (remote_raw),
    .remote_upper_limit (state.rem_upper),
    .remote_lower_limit (state.rem_lower),
    .remote_setpoint    (remote_sp),
    .remote_error       (remote_err_raw)
  );

  rate_alarm u_rate (
    .clk_sys       (clk_sys),
    .rst_b         (rst_b),
    .ce            (ce),
    .sample        (state.sample),
    .period        (state.rate_period),
    .process_value (process_value),
    .alarm_value   (rate_alarm_value),
    .rate_alarm    (rate_raw)
  );

  // ----------------------------------------------------------------------------
  // Selection and supervision
  // ----------------------------------------------------------------------------
  // Flag order matches the mask weights, lowest weight in bit zero.
  always_comb begin
    next_state = state;
    flags = {remote_err_raw, input_error, heater_short_alarm, heater_burnout_alarm,
             alarm_flags}; // see [RULE2]
    // Remote setpoint selection, tracking and indicator are dead while self-tuning runs.
    rem_active  = state.rem_enable && !self_tuning; // see [RULE9]
    sel_allowed = !self_tuning && ramp_distinct &&
                  ((alarm1_type >= 5'h01 && alarm1_type <= 5'h07) ||
                   alarm1_type == 5'h0e || alarm1_type == 5'h0f ||
                   alarm1_type == 5'h12 || alarm1_type == 5'h13); // see [RULE6]
    rem_limited = remote_sp;
    if (remote_sp > sp_upper_limit) begin
      rem_limited = sp_upper_limit; // see [RULE13]
    end else if (remote_sp < sp_lower_limit) begin
      rem_limited = sp_lower_limit;
    end
    // Sample divider produces one pulse per sampling period.
    if (state.div >= 23'(SAMPLE_DIV - 1)) begin
      next_state.div    = '0;
      next_state.sample = 1'b1;
    end else begin
      next_state.div    = state.div + 23'h000001;
      next_state.sample = 1'b0;
    end
    if (cfg_write) begin
      next_state.mask       = integrated_alarm_mask_in; // see [RULE3]
      next_state.in_type    = (remote_input_type_in > 3'(IN_0_10V)) ? state.in_type
                                                                    : remote_input_type_in;
      if (!self_tuning) begin
        next_state.rem_enable = remote_enable_in; // see [RULE9]
        next_state.tracking   = tracking_in;
        next_state.rem_upper  = remote_upper_limit_in;
        next_state.rem_lower  = remote_lower_limit_in;
      end
      next_state.man_limit  = manual_limit_enable_in;
      next_state.sp_target  = alarm_sp_target_in;
      next_state.soak_hours = soak_unit_hours_in;
      if (rate_period_in != 10'h000 && rate_period_in <= RATE_PERIOD_MAX) begin
        next_state.rate_period = rate_period_in; // see [RULE17]
      end
      next_state.cool_tune  = cool_tune_in;
    end
    if (state.sample) begin
      next_state.alarm = |(flags & state.mask); // see [RULE1] see [RULE19]
    end
    // Local setpoint: tracking copy on leaving remote mode beats an operator write.
    next_state.remote_prev = remote_mode && rem_active;
    if (state.remote_prev && !(remote_mode && rem_active) && state.tracking && rem_active) begin
      next_state.local_sp = remote_sp; // see [RULE14]
    end else if (local_setpoint_write) begin
      next_state.local_sp = local_setpoint_in;
    end
    next_state.ctrl_sp = (rem_active && remote_mode) ? rem_limited : state.local_sp; // see [RULE8]
    next_state.alarm_sp = (sel_allowed && state.sp_target) ? target_setpoint
                                                           : ramping_setpoint; // see [RULE5]
    next_state.man_out = manual_mv;
    if (manual_mode && state.man_limit) begin
      if (manual_mv > mv_upper_limit) begin
        next_state.man_out = mv_upper_limit; // see [RULE15]
      end else if (manual_mv < mv_lower_limit) begin
        next_state.man_out = mv_lower_limit;
      end
    end
    next_state.err       = remote_err_raw;
    next_state.ind       = rem_active && remote_mode && !(remote_err_raw && flash_phase); // see [RULE12]
    next_state.mon_blank = remote_err_raw && flash_phase;
    next_state.soak_out  = program_enabled && state.soak_hours; // see [RULE4]
    // Cooling method only matters under heating/cooling two-PID control.
    if (!heat_cool_two_pid) begin
      next_state.cool_out = 4'(COOL_SAME); // see [RULE18]
    end else begin
      unique case (state.cool_tune)
        2'h0: next_state.cool_out = 4'(COOL_SAME);
        2'h1: next_state.cool_out = 4'(COOL_LINEAR);
        2'h2: next_state.cool_out = 4'(COOL_AIR);
        2'h3: next_state.cool_out = 4'(COOL_WATER);
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state             <= '0;
      state.mask        <= MASK_RESET; // see [RULE3]
      state.in_type     <= IN_4_20MA; // see [RULE7]
      state.rem_upper   <= REMOTE_UPPER_RESET; // see [RULE10]
      state.rem_lower   <= REMOTE_LOWER_RESET;
      state.rate_period <= RATE_PERIOD_RESET;
      state.cool_tune   <= COOL_TUNE_RESET;
      state.cool_out    <= 4'(COOL_SAME);
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign integrated_alarm     = state.alarm;
  assign control_setpoint     = state.ctrl_sp;
  assign local_setpoint       = state.local_sp;
  assign alarm_setpoint       = state.alarm_sp;
  assign manual_output        = state.man_out;
  assign remote_error         = state.err;
  assign remote_indicator     = state.ind;
  assign remote_monitor_blank = state.mon_blank;
  assign rate_change_alarm    = rate_raw;
  assign soak_unit_hours      = state.soak_out;
  assign cool_tune_method     = state.cool_out;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  sequence s_sampled_flags;
    ce && state.sample;
  endsequence

  property p_alarm_or;
    @(posedge clk_sys) disable iff (!rst_b)
    s_sampled_flags |=> integrated_alarm == |($past(flags) & $past(state.mask));
  endproperty
  a_alarm_or: assert property (p_alarm_or) else $error("integrated alarm wrong"); // see [RULE1]

  property p_local_only;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && !rem_active) |=> control_setpoint == $past(state.local_sp);
  endproperty
  a_local_only: assert property (p_local_only) else $error("remote used while off"); // see [RULE8]

  property p_sp_limits;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && rem_active && remote_mode && sp_lower_limit <= sp_upper_limit)
      |=> control_setpoint <= $past(sp_upper_limit) && control_setpoint >= $past(sp_lower_limit);
  endproperty
  a_sp_limits: assert property (p_sp_limits) else $error("setpoint out of limits"); // see [RULE13]

  property p_alarm_sp_ramp;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && !sel_allowed) |=> alarm_setpoint == $past(ramping_setpoint);
  endproperty
  a_alarm_sp_ramp: assert property (p_alarm_sp_ramp) else $error("alarm SP select leaked"); // see [RULE6]

  property p_manual_limit;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && manual_mode && state.man_limit && manual_mv > mv_upper_limit)
      |=> manual_output == $past(mv_upper_limit);
  endproperty
  a_manual_limit: assert property (p_manual_limit) else $error("manual limit ignored"); // see [RULE15]

  property p_tune_lock;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && self_tuning) |=> $stable(state.rem_enable) && $stable(state.tracking);
  endproperty
  a_tune_lock: assert property (p_tune_lock) else $error("remote set under self-tuning"); // see [RULE9]

  property p_soak;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && !program_enabled) |=> !soak_unit_hours;
  endproperty
  a_soak: assert property (p_soak) else $error("soak unit without program"); // see [RULE4]

  property p_cool;
    @(posedge clk_sys) disable iff (!rst_b)
    (ce && !heat_cool_two_pid) |=> cool_tune_method == 4'(COOL_SAME);
  endproperty
  a_cool: assert property (p_cool) else $error("cool tune outside two-PID"); // see [RULE18]

endmodule : setpoint_select_alarm_combine

/* rtl/sp_alarm_pkg.sv */
// Contract
// [RULE1] Integrated alarm output is OR of the eight status flags selected by the mask.
// [RULE2] Mask weights: alarms 1-4 are 1,2,4,8; burnout 16, short 32, input 64, remote 128.
// [RULE3] Mask spans 0 to 255 and resets to 49.
// [RULE4] Soak timer unit is minutes or hours, minutes by default, only with a program pattern.
// [RULE5] Alarm compare setpoint selects ramping or target; ramping after reset.
// [RULE6] That selection acts only for listed alarm types, self-tuning off, distinct ramp rates.
// [RULE7] Remote input type is one of five ranges, 4-20 mA by default.
// [RULE8] Remote enable lets setpoint mode pick remote; otherwise local only; off by default.
// [RULE9] Remote enable, limits and tracking only act while self-tuning is off.
// [RULE10] Remote input scales linearly between remote lower and upper limits, -200 and 1300.
// [RULE11] Remote value over 10 percent outside the limits raises an error and is clamped.
// [RULE12] On remote error, remote indicator flashes in remote mode; monitor flashes always.
// [RULE13] Remote setpoint used for control is also held within setpoint limits.
// [RULE14] Remote to local switch with tracking copies remote into local setpoint.
// [RULE15] Manual limit enable, off by default, applies output limits to manual output.
// [RULE16] Type 13 alarm fires when the change over one period exceeds the alarm value.
// [RULE17] Rate period counts 50 ms samples, 1 to 999, default 20.
// [RULE18] Cooling tuning method codes 0 to 3, default 0, only for heat/cool two-PID.
// [RULE19] Integrated alarm is recomputed from the flags every sampling cycle.
package sp_alarm_pkg;

  // ----------------------------------------------------------------------------
  // Mask bit positions and reset values
  // ----------------------------------------------------------------------------
  localparam int unsigned  MASK_ALARM1    = 0;
  localparam int unsigned  MASK_BURNOUT   = 4;
  localparam int unsigned  MASK_SHORT     = 5;
  localparam int unsigned  MASK_INPUT_ERR = 6;
  localparam int unsigned  MASK_REMOTE    = 7;
  localparam logic [7:0]   MASK_RESET     = 8'h31;
  localparam logic [15:0]  REMOTE_UPPER_RESET = 16'h0514;
  localparam logic [15:0]  REMOTE_LOWER_RESET = 16'hff38;
  localparam logic [9:0]   RATE_PERIOD_RESET  = 10'h014;
  localparam logic [9:0]   RATE_PERIOD_MAX    = 10'h3e7;
  localparam logic [1:0]   COOL_TUNE_RESET    = 2'h0;
  // Input code full scale for the remote converter and margin fraction (1/10).
  localparam logic [15:0]  INPUT_FULL_SCALE   = 16'h1000;
  localparam int unsigned  MARGIN_DIV         = 10;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int unsigned  CLK_PERIOD_NS   = 100;
  localparam int unsigned  SAMPLE_MS       = 50;
  localparam int unsigned  SAMPLE_CYCLES   = SAMPLE_MS * 1000000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    IN_4_20MA = 3'h0, IN_0_20MA = 3'h1, IN_1_5V = 3'h2, IN_0_5V = 3'h3, IN_0_10V = 3'h4
  } remote_input_type_t;

  typedef enum logic [3:0] {
    COOL_SAME = 4'h1, COOL_LINEAR = 4'h2, COOL_AIR = 4'h4, COOL_WATER = 4'h8
  } cool_tune_t;

  localparam logic [4:0]   RATE_ALARM_TYPE = 5'h0d;

endpackage : sp_alarm_pkg

/* tb/plant_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Sensor front end stand-in
// ----------------------------------------------------------------------------
module plant_model (
  input  wire logic               clk_sys,
  input  wire logic [7:0]         flags_req,
  input  wire logic signed [15:0] pv_step,
  input  wire logic [15:0]        raw_req,
  output logic [3:0]              alarm_flags,
  output logic                    heater_burnout_alarm,
  output logic                    heater_short_alarm,
  output logic                    input_error,
  output logic signed [15:0]      process_value,
  output logic [15:0]             remote_raw
);
  // The process value ramps by pv_step per cycle, like a heating load.
  initial process_value = 16'sh0000;
  // Updates land just after the edge so the block never samples a moving value.
  always @(posedge clk_sys) begin
    #1;
    {input_error, heater_short_alarm, heater_burnout_alarm, alarm_flags} <= flags_req[6:0];
    process_value <= process_value + pv_step;
    remote_raw <= raw_req;
  end
endmodule : plant_model

/* tb/tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb;
  import sp_alarm_pkg::*;
  localparam int DIV = 4;
  localparam int W = 2 * DIV + 3;
  logic clk_sys = 0, rst_b = 0, ce = 1, cfg_write = 0, local_setpoint_write = 0;
  logic [7:0] integrated_alarm_mask_in = 8'h31, flags_req = 8'h00;
  logic [2:0] remote_input_type_in = 3'h0;
  logic signed [15:0] remote_upper_limit_in = REMOTE_UPPER_RESET;
  logic signed [15:0] remote_lower_limit_in = REMOTE_LOWER_RESET;
  logic remote_enable_in = 0, tracking_in = 0, manual_limit_enable_in = 0, alarm_sp_target_in = 0;
  logic soak_unit_hours_in = 0, self_tuning = 0, program_enabled = 1, heat_cool_two_pid = 1;
  logic ramp_distinct = 1, remote_mode = 1, manual_mode = 1, flash_phase = 1;
  logic [9:0] rate_period_in = 10'h001;
  logic [1:0] cool_tune_in = 2'h0;
  logic [4:0] alarm1_type = 5'h01;
  logic signed [15:0] pv_step = 16'h0000, rate_alarm_value = 16'h0032;
  logic signed [15:0] ramping_setpoint = 16'h0064, target_setpoint = 16'h00c8;
  logic signed [15:0] local_setpoint_in = 16'h007b, manual_mv = 16'h01f4;
  logic signed [15:0] sp_upper_limit = 16'h0514, sp_lower_limit = 16'hff38;
  logic signed [15:0] mv_upper_limit = 16'h012c, mv_lower_limit = 16'h0064, manual_output;
  logic [15:0] raw_req = 16'h0000, remote_raw;
  logic [3:0] alarm_flags, cool_tune_method;
  logic heater_burnout_alarm, heater_short_alarm, input_error, integrated_alarm, remote_error;
  logic remote_indicator, remote_monitor_blank, rate_change_alarm, soak_unit_hours;
  logic signed [15:0] process_value, control_setpoint, local_setpoint, alarm_setpoint;
  int n_fail = 0, checked = 0, cyc = 0;
  plant_model u_plant (.clk_sys, .flags_req, .pv_step, .raw_req, .alarm_flags,
    .heater_burnout_alarm, .heater_short_alarm, .input_error, .process_value, .remote_raw);
  setpoint_select_alarm_combine #(.SAMPLE_DIV(DIV)) u_dut (.clk_sys, .rst_b, .ce, .cfg_write,
    .integrated_alarm_mask_in, .remote_input_type_in, .remote_upper_limit_in,
    .remote_lower_limit_in, .remote_enable_in, .tracking_in, .manual_limit_enable_in,
    .alarm_sp_target_in, .soak_unit_hours_in, .rate_period_in, .cool_tune_in, .self_tuning,
    .program_enabled, .heat_cool_two_pid, .ramp_distinct, .alarm1_type, .remote_mode,
    .manual_mode, .flash_phase, .alarm_flags, .heater_burnout_alarm, .heater_short_alarm,
    .input_error, .remote_raw, .process_value, .rate_alarm_value, .ramping_setpoint,
    .target_setpoint, .local_setpoint_in, .local_setpoint_write, .sp_upper_limit,
    .sp_lower_limit, .manual_mv, .mv_upper_limit, .mv_lower_limit, .integrated_alarm,
    .control_setpoint, .local_setpoint, .alarm_setpoint, .manual_output, .remote_error,
    .remote_indicator, .remote_monitor_blank, .rate_change_alarm, .soak_unit_hours,
    .cool_tune_method);
  // ----------------------------------------------------------------------------
  // Clock, hang guard and access tasks
  // ----------------------------------------------------------------------------
  always #50 clk_sys = ~clk_sys;
  // A stuck sequence would otherwise run forever; 3000 cycles is ample margin.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // Every write loads all settings (remote enable, tracking and limits only with self-tuning off), so the bench keeps each one at a legal value.
  task automatic wr_cfg();
    cfg_write = 1;
    tick(1);
    cfg_write = 0;
  endtask : wr_cfg
  task automatic tally_and_finish();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------------
  initial begin
    tick(16);
    rst_b = 1;
    `CHK("cool_reset", 4'h1, cool_tune_method)
    tick(2);
    `CHK("alarm_sp_ramp", ramping_setpoint, alarm_setpoint)
    flags_req = 8'h02;
    tick(W);
    `CHK("mask_default_off", 1'b0, integrated_alarm)
    flags_req = 8'h30;
    tick(W);
    `CHK("mask_default_on", 1'b1, integrated_alarm)
    // Each weight below 128 must see its own flag and ignore all the others.
    for (int i = 0; i < 7; i++) begin
      integrated_alarm_mask_in = 8'h01 << i;
      flags_req = 8'h7f & ~(8'h01 << i);
      wr_cfg();
      tick(W);
      `CHK("mask_other", 1'b0, integrated_alarm)
      flags_req = 8'h01 << i;
      tick(W);
      `CHK("mask_own", 1'b1, integrated_alarm)
    end
    flags_req = 8'h00;
    tick(W);
    `CHK("alarm_follows", 1'b0, integrated_alarm)
    for (int i = 0; i < 4; i++) begin
      cool_tune_in = 2'(i);
      soak_unit_hours_in = i[0];
      wr_cfg();
      tick(2);
      `CHK("cool_code", 4'h1 << i, cool_tune_method)
      `CHK("soak_unit", i[0], soak_unit_hours)
    end
    alarm_sp_target_in = 1;
    manual_limit_enable_in = 1;
    wr_cfg();
    tick(2);
    `CHK("alarm_sp_target", target_setpoint, alarm_setpoint)
    `CHK("manual_limited", 16'sh012c, manual_output)
    // Self-tuning must block both the alarm selection and a remote enable write.
    self_tuning = 1;
    remote_enable_in = 1;
    local_setpoint_write = 1;
    wr_cfg();
    local_setpoint_write = 0;
    tick(W);
    `CHK("alarm_sp_tuning", ramping_setpoint, alarm_setpoint)
    `CHK("remote_refused", 16'sh007b, control_setpoint)
    `CHK("local_write", 16'sh007b, local_setpoint)
    self_tuning = 0;
    tracking_in = 1;
    integrated_alarm_mask_in = 8'h80;
    manual_limit_enable_in = 0;
    wr_cfg();
    tick(2 * W);
    `CHK("manual_free", 16'sh01f4, manual_output)
    `CHK("remote_err", 1'b1, remote_error)
    `CHK("remote_clamp", 16'shff38, control_setpoint)
    `CHK("remote_err_mask", 1'b1, integrated_alarm)
    `CHK("rem_flash", 1'b0, remote_indicator)
    `CHK("mon_flash", 1'b1, remote_monitor_blank)
    remote_input_type_in = 3'h4;
    raw_req = 16'h0800;
    wr_cfg();
    tick(2 * W);
    `CHK("remote_scale", 16'sh0226, control_setpoint)
    `CHK("rem_lit", 1'b1, remote_indicator)
    `CHK("mon_steady", 1'b0, remote_monitor_blank)
    sp_upper_limit = 16'h0190;
    tick(W);
    `CHK("remote_sp_limit", 16'sh0190, control_setpoint)
    remote_mode = 0;
    pv_step = 16'h0014;
    tick(W);
    `CHK("track_copy", 16'sh0226, local_setpoint)
    `CHK("rate_fast", 1'b1, rate_change_alarm)
    pv_step = 16'h000a;
    tick(W);
    `CHK("rate_slow", 1'b0, rate_change_alarm)
    tally_and_finish();
  end
endmodule : tb
